// File: rtl/dummy_latency_pkg.sv
// constants, opcodes and state type for the read dummy-cycle latency block
package dummy_latency_pkg;

   // read opcodes on the link
   localparam logic [7:0] OP_FAST_READ = 8'h0b;
   localparam logic [7:0] OP_FAST_READ_DR = 8'h0d;
   localparam logic [7:0] OP_DUAL_OUT = 8'h3b;
   localparam logic [7:0] OP_DUAL_IO = 8'hbb;
   localparam logic [7:0] OP_DUAL_IO_DR = 8'hbd;
   localparam logic [7:0] OP_QUAD_OUT = 8'h6b;
   localparam logic [7:0] OP_QUAD_IO = 8'heb;
   localparam logic [7:0] OP_QUAD_IO_DR = 8'hed;

   // default dummy counts when the setting is zero
   localparam logic [4:0] DFLT_FAST_SINGLE = 5'h08;
   localparam logic [4:0] DFLT_FAST_QUAD = 5'h06;
   localparam logic [4:0] DFLT_DUAL_OUT = 5'h08;
   localparam logic [4:0] DFLT_DUAL_IO = 5'h04;
   localparam logic [4:0] DFLT_QUAD_OUT = 5'h08;
   localparam logic [4:0] DFLT_QUAD_IO = 5'h06;

   // address cycles for a 24-bit address per line count and rate
   localparam logic [4:0] ADDR_X1 = 5'h18;
   localparam logic [4:0] ADDR_X1_DR = 5'h0c;
   localparam logic [4:0] ADDR_X2 = 5'h0c;
   localparam logic [4:0] ADDR_X2_DR = 5'h06;
   localparam logic [4:0] ADDR_X4 = 5'h06;
   localparam logic [4:0] ADDR_X4_DR = 5'h03;
   localparam logic [4:0] NO_ADDR = 5'h00;

   // last opcode cycle index: one line or four lines
   localparam logic [4:0] OPC_LAST_SINGLE = 5'h07;
   localparam logic [4:0] OPC_LAST_QUAD = 5'h01;

   // data lane masks on io[3:0]; single line data leaves on io1
   localparam logic [3:0] LANE_X1 = 4'h2;
   localparam logic [3:0] LANE_X2 = 4'h3;
   localparam logic [3:0] LANE_X4 = 4'hf;

   typedef enum logic [4:0] {
      ST_OPCODE = 5'h01,
      ST_ADDR = 5'h02,
      ST_DUMMY = 5'h04,
      ST_DATA = 5'h08,
      ST_IGNORE = 5'h10
   } link_state_type;

endpackage

// File: rtl/level_sync.sv
// two-flop synchroniser for levels and quasi-static words
`timescale 1ns/1ns
module level_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk,
   input wire logic rstN,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);

   logic [WIDTH-1:0] meta_ff;
   logic [WIDTH-1:0] hold_ff;

   // first stage feeds only the second stage
   always_ff @(posedge clk or negedge rstN)
   begin
      if (!rstN)
      begin
         meta_ff <= '0;
         hold_ff <= '0;
      end
      else
      begin
         meta_ff <= d;
         hold_ff <= meta_ff;
      end
   end

   assign q = hold_ff;

endmodule // level_sync

// File: rtl/read_dummy_latency.sv
// device-side read dummy-cycle latency control on a serial flash link
// Contract
// - nonzero 4-bit setting gives 1..15 dummy cycles; zero gives defaults
// - fast read and its double rate: 8 single-line, 6 four-line
// - dual-output fast read defaults to 8; no double rate form
// - dual io fast read and its double rate default to 4
// - quad-output fast read defaults to 8; no double rate form
// - quad io fast read and double rate default to 6, both modes
// - dual io double rate read only in single-line command mode
// - single-line: unique-id, param, info-row reads follow fast read count
// - four-line: unique-id and info-row reads follow fast read count
`timescale 1ns/1ns
module read_dummy_latency #(
   parameter logic [7:0] UNIQUE_ID_OP = 8'h4b,
   parameter logic [7:0] PARAM_READ_OP = 8'h5a,
   parameter logic [7:0] INFO_ROW_OP = 8'h68
) (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic linkClk,
   input wire logic linkSelN,
   input wire logic [3:0] ioIn,
   input wire logic [3:0] dummySetting,
   input wire logic quadCmdMode,
   input wire logic [7:0] readByte,
   output logic [3:0] ioOut_ff,
   output logic [3:0] ioOe_ff,
   output logic dataStart_ff,
   output logic [4:0] latencyUsed_ff
);

   dummy_latency_pkg::link_state_type state_ff;
   logic frameRstN;
   logic [12:0] cfgSync;
   logic [3:0] cfgSetting;
   logic cfgQuad;
   logic [7:0] cfgByte;
   logic [4:0] cnt_ff;
   logic [7:0] op_ff;
   logic [7:0] nxtOp;
   logic [4:0] opLast;
   logic [3:0] lanes_ff;
   logic [7:0] shift_ff;
   logic enterDummy;
   logic dummyLast;
   logic [4:0] nxtDummy;
   logic doneTgl_ff;
   logic [4:0] dummyUsed_ff;
   logic tglSync;
   logic tglSeen_ff;

   // frame logic is cleared whenever the select is high, so no link
   // edge is needed after a frame ends
   assign frameRstN = nrst & ~linkSelN;

   // config is quasi-static: change it only between frames
   level_sync #(.WIDTH(13)) u_cfg_sync (
      .clk(linkClk),
      .rstN(nrst),
      .d({dummySetting, quadCmdMode, readByte}),
      .q(cfgSync)
   );
   assign cfgSetting = cfgSync[12:9];
   assign cfgQuad = cfgSync[8];
   assign cfgByte = cfgSync[7:0];

   function automatic logic isAux(input logic [7:0] op, input logic quad);
      isAux = (op == UNIQUE_ID_OP) || (op == INFO_ROW_OP)
         || (!quad && op == PARAM_READ_OP);
   endfunction

   function automatic logic [4:0] addrCycles(input logic [7:0] op,
                                             input logic quad);
      addrCycles = dummy_latency_pkg::NO_ADDR;
      if (quad)
      begin
         if (op == dummy_latency_pkg::OP_FAST_READ
             || op == dummy_latency_pkg::OP_QUAD_IO || isAux(op, quad))
            addrCycles = dummy_latency_pkg::ADDR_X4;
         else if (op == dummy_latency_pkg::OP_FAST_READ_DR
                  || op == dummy_latency_pkg::OP_QUAD_IO_DR)
            addrCycles = dummy_latency_pkg::ADDR_X4_DR;
         // dual io double rate is not taken here: frame ignored
      end
      else if (isAux(op, quad))
         addrCycles = dummy_latency_pkg::ADDR_X1;
      else
      begin
         case (op)
            dummy_latency_pkg::OP_FAST_READ,
            dummy_latency_pkg::OP_DUAL_OUT,
            dummy_latency_pkg::OP_QUAD_OUT:
               addrCycles = dummy_latency_pkg::ADDR_X1;
            dummy_latency_pkg::OP_FAST_READ_DR:
               addrCycles = dummy_latency_pkg::ADDR_X1_DR;
            dummy_latency_pkg::OP_DUAL_IO:
               addrCycles = dummy_latency_pkg::ADDR_X2;
            dummy_latency_pkg::OP_DUAL_IO_DR:
               addrCycles = dummy_latency_pkg::ADDR_X2_DR;
            dummy_latency_pkg::OP_QUAD_IO:
               addrCycles = dummy_latency_pkg::ADDR_X4;
            dummy_latency_pkg::OP_QUAD_IO_DR:
               addrCycles = dummy_latency_pkg::ADDR_X4_DR;
            default:
               addrCycles = dummy_latency_pkg::NO_ADDR;
         endcase
      end
   endfunction

   function automatic logic [4:0] defaultDummy(input logic [7:0] op,
                                               input logic quad);
      defaultDummy = dummy_latency_pkg::DFLT_FAST_SINGLE;
      if (quad)
      begin
         if (op == dummy_latency_pkg::OP_QUAD_IO
             || op == dummy_latency_pkg::OP_QUAD_IO_DR)
            defaultDummy = dummy_latency_pkg::DFLT_QUAD_IO;
         else
            defaultDummy = dummy_latency_pkg::DFLT_FAST_QUAD;
      end
      else
      begin
         case (op)
            dummy_latency_pkg::OP_DUAL_OUT:
               defaultDummy = dummy_latency_pkg::DFLT_DUAL_OUT;
            dummy_latency_pkg::OP_DUAL_IO,
            dummy_latency_pkg::OP_DUAL_IO_DR:
               defaultDummy = dummy_latency_pkg::DFLT_DUAL_IO;
            dummy_latency_pkg::OP_QUAD_OUT:
               defaultDummy = dummy_latency_pkg::DFLT_QUAD_OUT;
            dummy_latency_pkg::OP_QUAD_IO,
            dummy_latency_pkg::OP_QUAD_IO_DR:
               defaultDummy = dummy_latency_pkg::DFLT_QUAD_IO;
            default:
               defaultDummy = dummy_latency_pkg::DFLT_FAST_SINGLE;
         endcase
      end
   endfunction

   function automatic logic [3:0] dataLanes(input logic [7:0] op,
                                            input logic quad);
      dataLanes = dummy_latency_pkg::LANE_X1;
      if (quad)
         dataLanes = dummy_latency_pkg::LANE_X4;
      else if (op == dummy_latency_pkg::OP_DUAL_OUT
               || op == dummy_latency_pkg::OP_DUAL_IO
               || op == dummy_latency_pkg::OP_DUAL_IO_DR)
         dataLanes = dummy_latency_pkg::LANE_X2;
      else if (op == dummy_latency_pkg::OP_QUAD_OUT
               || op == dummy_latency_pkg::OP_QUAD_IO
               || op == dummy_latency_pkg::OP_QUAD_IO_DR)
         dataLanes = dummy_latency_pkg::LANE_X4;
   endfunction

   function automatic logic [3:0] laneBits(input logic [7:0] s,
                                           input logic [3:0] lanes);
      if (lanes == dummy_latency_pkg::LANE_X4)
         laneBits = s[7:4];
      else if (lanes == dummy_latency_pkg::LANE_X2)
         laneBits = {2'b00, s[7:6]};
      else
         laneBits = {2'b00, s[7], 1'b0};
   endfunction

   // rotation repeats the byte so a long burst never runs dry
   function automatic logic [7:0] rotBits(input logic [7:0] s,
                                          input logic [3:0] lanes);
      if (lanes == dummy_latency_pkg::LANE_X4)
         rotBits = {s[3:0], s[7:4]};
      else if (lanes == dummy_latency_pkg::LANE_X2)
         rotBits = {s[5:0], s[7:6]};
      else
         rotBits = {s[6:0], s[7]};
   endfunction

   assign nxtOp = cfgQuad ? {op_ff[3:0], ioIn} : {op_ff[6:0], ioIn[0]};
   assign opLast = cfgQuad ? dummy_latency_pkg::OPC_LAST_QUAD
                           : dummy_latency_pkg::OPC_LAST_SINGLE;
   assign enterDummy = (state_ff == dummy_latency_pkg::ST_ADDR)
                       && (cnt_ff == 5'h01);
   assign dummyLast = (state_ff == dummy_latency_pkg::ST_DUMMY)
                      && (cnt_ff == 5'h01);
   // mode bits sit inside the dummy span, as the host expects
   assign nxtDummy = (cfgSetting != 4'h0) ? {1'b0, cfgSetting}
                     : defaultDummy(op_ff, cfgQuad);

   // command sequencing on the link clock
   always_ff @(posedge linkClk or negedge frameRstN)
   begin
      if (!frameRstN)
      begin
         state_ff <= dummy_latency_pkg::ST_OPCODE;
         cnt_ff <= 5'h00;
         op_ff <= 8'h00;
         lanes_ff <= dummy_latency_pkg::LANE_X1;
      end
      else
      begin
         case (state_ff)
            dummy_latency_pkg::ST_OPCODE:
            begin
               op_ff <= nxtOp;
               if (cnt_ff != opLast)
                  cnt_ff <= cnt_ff + 5'h01;
               else if (addrCycles(nxtOp, cfgQuad)
                        == dummy_latency_pkg::NO_ADDR)
                  state_ff <= dummy_latency_pkg::ST_IGNORE;
               else
               begin
                  state_ff <= dummy_latency_pkg::ST_ADDR;
                  cnt_ff <= addrCycles(nxtOp, cfgQuad);
                  lanes_ff <= dataLanes(nxtOp, cfgQuad);
               end
            end
            dummy_latency_pkg::ST_ADDR:
            begin
               if (enterDummy)
               begin
                  state_ff <= dummy_latency_pkg::ST_DUMMY;
                  cnt_ff <= nxtDummy;
               end
               else
                  cnt_ff <= cnt_ff - 5'h01;
            end
            dummy_latency_pkg::ST_DUMMY:
            begin
               if (dummyLast)
                  state_ff <= dummy_latency_pkg::ST_DATA;
               cnt_ff <= cnt_ff - 5'h01;
            end
            dummy_latency_pkg::ST_DATA:
               state_ff <= dummy_latency_pkg::ST_DATA;
            default:
               state_ff <= dummy_latency_pkg::ST_IGNORE;
         endcase
      end
   end

   // pin drive: floating until the last dummy edge has passed
   always_ff @(posedge linkClk or negedge frameRstN)
   begin
      if (!frameRstN)
      begin
         ioOe_ff <= 4'h0;
         ioOut_ff <= 4'h0;
         shift_ff <= 8'h00;
      end
      else if (dummyLast)
      begin
         ioOe_ff <= lanes_ff;
         ioOut_ff <= laneBits(cfgByte, lanes_ff);
         shift_ff <= rotBits(cfgByte, lanes_ff);
      end
      else if (state_ff == dummy_latency_pkg::ST_DATA)
      begin
         ioOut_ff <= laneBits(shift_ff, lanes_ff);
         shift_ff <= rotBits(shift_ff, lanes_ff);
      end
      else
         ioOe_ff <= 4'h0;
   end

   // report toggle survives frame ends, so it sits on the plain reset
   always_ff @(posedge linkClk or negedge nrst)
   begin
      if (!nrst)
      begin
         doneTgl_ff <= 1'b0;
         dummyUsed_ff <= 5'h00;
      end
      else
      begin
         if (enterDummy)
            dummyUsed_ff <= nxtDummy;
         if (dummyLast)
            doneTgl_ff <= ~doneTgl_ff;
      end
   end

   level_sync #(.WIDTH(1)) u_tgl_sync (
      .clk(ref_clk),
      .rstN(nrst),
      .d(doneTgl_ff),
      .q(tglSync)
   );

   // the count word is stable long before its toggle arrives here
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         tglSeen_ff <= 1'b0;
         dataStart_ff <= 1'b0;
         latencyUsed_ff <= 5'h00;
      end
      else
      begin
         tglSeen_ff <= tglSync;
         dataStart_ff <= tglSync ^ tglSeen_ff;
         if (tglSync ^ tglSeen_ff)
            latencyUsed_ff <= dummyUsed_ff;
      end
   end

   default clocking cb @(posedge linkClk);
   endclocking
   default disable iff (!frameRstN);

   sequence sDummyLast;
      state_ff == dummy_latency_pkg::ST_DUMMY && cnt_ff == 5'h01;
   endsequence
   sequence sDefaultEntry;
      enterDummy && cfgSetting == 4'h0;
   endsequence

   a_dummy_float: assert property (
      state_ff == dummy_latency_pkg::ST_DUMMY |-> ioOe_ff == 4'h0)
      else $error("data driven during dummy cycles");
   a_drive_after_last: assert property (
      sDummyLast |=> state_ff == dummy_latency_pkg::ST_DATA
                     && ioOe_ff == lanes_ff)
      else $error("data not driven right after last dummy cycle");
   a_setting_count: assert property (
      enterDummy && cfgSetting != 4'h0 |=> cnt_ff == {1'b0, $past(cfgSetting)}
      ##1 cnt_ff == {1'b0, $past(cfgSetting, 2)} - 5'h01)
      else $error("programmed dummy count not used");
   a_fast_read_dflt: assert property (
      sDefaultEntry ##0 (op_ff == dummy_latency_pkg::OP_FAST_READ
         || op_ff == dummy_latency_pkg::OP_FAST_READ_DR)
      |=> cnt_ff == ($past(cfgQuad) ? 5'h06 : 5'h08))
      else $error("fast read default dummy count wrong");
   a_dual_out_dflt: assert property (
      sDefaultEntry ##0 op_ff == dummy_latency_pkg::OP_DUAL_OUT
      |=> cnt_ff == 5'h08)
      else $error("dual output default dummy count wrong");
   a_dual_io_dflt: assert property (
      sDefaultEntry ##0 (op_ff == dummy_latency_pkg::OP_DUAL_IO
         || op_ff == dummy_latency_pkg::OP_DUAL_IO_DR) |=> cnt_ff == 5'h04)
      else $error("dual io default dummy count wrong");
   a_quad_out_dflt: assert property (
      sDefaultEntry ##0 op_ff == dummy_latency_pkg::OP_QUAD_OUT
      |=> cnt_ff == 5'h08)
      else $error("quad output default dummy count wrong");
   a_quad_io_dflt: assert property (
      sDefaultEntry ##0 (op_ff == dummy_latency_pkg::OP_QUAD_IO
         || op_ff == dummy_latency_pkg::OP_QUAD_IO_DR) |=> cnt_ff == 5'h06)
      else $error("quad io default dummy count wrong");
   a_dual_dr_refused: assert property (
      state_ff == dummy_latency_pkg::ST_OPCODE && cnt_ff == opLast
      && cfgQuad && nxtOp == dummy_latency_pkg::OP_DUAL_IO_DR
      |=> state_ff == dummy_latency_pkg::ST_IGNORE [*2])
      else $error("dual io double rate taken in four-line mode");
   a_aux_single: assert property (
      sDefaultEntry ##0 !cfgQuad && isAux(op_ff, 1'b0) |=> cnt_ff == 5'h08)
      else $error("auxiliary read count differs in single-line mode");
   a_aux_quad: assert property (
      sDefaultEntry ##0 cfgQuad && isAux(op_ff, 1'b1) |=> cnt_ff == 5'h06)
      else $error("auxiliary read count differs in four-line mode");

endmodule // read_dummy_latency

// File: tb/link_host_model.sv
// host controller model that drives reads over the serial link
`timescale 1ns/1ns
module link_host_model (
   output logic linkClk,
   output logic linkSelN,
   output logic [3:0] ioIn,
   input wire logic [3:0] ioOut,
   input wire logic [3:0] ioOe
);
   // 64 ns link clock sits below every documented frequency limit
   localparam int HALF = 32;

   initial
   begin
      linkClk = 1'b0;
      linkSelN = 1'b1;
      ioIn = 4'h5;
   end

   // data changes after the falling edge, device samples on the rise
   task automatic pulse(input logic [3:0] v);
      ioIn = v;
      #HALF linkClk = 1'b1;
      #HALF linkClk = 1'b0;
   endtask

   task automatic frame(input logic [7:0] op, input logic quad,
         input int addrEdges, input int lanes, input int limit,
         output int dCount, output logic [3:0] oeSeen,
         output logic [7:0] dataSeen);
      int k;
      dCount = 0;
      oeSeen = 4'h0;
      dataSeen = 8'h00;
      // deselected edges let the config synchroniser settle
      repeat (3) pulse(~ioIn);
      linkSelN = 1'b0;
      if (quad)
      begin
         pulse(op[7:4]);
         pulse(op[3:0]);
      end
      else
         for (k = 7; k >= 0; k--)
            pulse({~ioIn[3:1], op[k]});
      repeat (addrEdges) pulse(~ioIn);
      // no mode bits are sent, so any count covers them
      for (k = 1; k <= limit; k++)
      begin
         // released lines keep changing rather than hold a value
         pulse(~ioIn);
         if (ioOe != 4'h0)
         begin
            dCount = k;
            oeSeen = ioOe;
            break;
         end
      end
      if (dCount > 0)
         for (k = 0; k < 8 / lanes; k++)
         begin
            if (k > 0)
               pulse(~ioIn);
            if (lanes == 1)
               dataSeen = {dataSeen[6:0], ioOut[1]};
            else if (lanes == 2)
               dataSeen = {dataSeen[5:0], ioOut[1], ioOut[0]};
            else
               dataSeen = {dataSeen[3:0], ioOut};
         end
      linkSelN = 1'b1;
      #HALF ioIn = ~ioIn;
   endtask
endmodule // link_host_model

// File: tb/read_dummy_latency_bench.sv
// self-checking bench for the read dummy-cycle latency block
`timescale 1ns/1ns
module read_dummy_latency_bench;
   localparam logic [7:0] UID = 8'h4b;
   localparam logic [7:0] PRM = 8'h5a;
   localparam logic [7:0] INF = 8'h68;
   logic ref_clk, nrst, linkClk, linkSelN, quadCmdMode, dataStart_ff;
   logic [3:0] ioIn, dummySetting, ioOut_ff, ioOe_ff;
   logic [7:0] readByte, rnd, x;
   logic [4:0] latencyUsed_ff;
   int errors, total_checks, pulses;
   // opcode table; a zero four-line address count marks a refusal
   logic [7:0] ops [11] = '{8'h0b, 8'h0d, 8'h3b, 8'hbb, 8'hbd, 8'h6b,
      8'heb, 8'hed, UID, PRM, INF};
   int aS [11] = '{24, 12, 24, 12, 6, 24, 6, 3, 24, 24, 24};
   int aQ [11] = '{6, 3, 0, 0, 0, 0, 6, 3, 6, 0, 6};
   int dS [11] = '{8, 8, 8, 4, 4, 8, 6, 6, 8, 8, 8};
   int dQ [11] = '{6, 6, 0, 0, 0, 0, 6, 6, 6, 0, 6};
   int lS [11] = '{1, 1, 2, 2, 2, 4, 4, 4, 1, 1, 1};

   read_dummy_latency #(.UNIQUE_ID_OP(UID), .PARAM_READ_OP(PRM),
         .INFO_ROW_OP(INF)) DUT (
      .ref_clk(ref_clk), .nrst(nrst), .linkClk(linkClk),
      .linkSelN(linkSelN), .ioIn(ioIn), .dummySetting(dummySetting),
      .quadCmdMode(quadCmdMode), .readByte(readByte),
      .ioOut_ff(ioOut_ff), .ioOe_ff(ioOe_ff),
      .dataStart_ff(dataStart_ff), .latencyUsed_ff(latencyUsed_ff));

   link_host_model host (.linkClk(linkClk), .linkSelN(linkSelN),
      .ioIn(ioIn), .ioOut(ioOut_ff), .ioOe(ioOe_ff));

   initial
   begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   always @(posedge ref_clk)
      if (dataStart_ff === 1'b1)
         pulses++;

   function automatic logic [7:0] nxt_rand(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction

   // expected dummy count: a nonzero setting wins over the table
   function automatic int expect_dummy(input int i, input logic q,
         input logic [3:0] s);
      if (s != 4'h0)
         return int'(s);
      return q ? dQ[i] : dS[i];
   endfunction

   task automatic chk(input logic [7:0] got, input logic [7:0] exp,
         input string what);
      total_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // one read frame; limit below the count cuts the frame in its dummy
   task automatic run(input int i, input logic q, input logic [3:0] s,
         input int limit);
      int a, d, dc, p0;
      bit ok;
      logic [3:0] oe, lm;
      logic [7:0] dat, b;
      b = rnd;
      rnd = nxt_rand(rnd);
      ok = !(q && aQ[i] == 0);
      a = q ? (ok ? aQ[i] : 6) : aS[i];
      d = expect_dummy(i, q, s);
      ok = ok && limit >= d;
      lm = (q || lS[i] == 4) ? dummy_latency_pkg::LANE_X4 :
         (lS[i] == 2 ? dummy_latency_pkg::LANE_X2 :
         dummy_latency_pkg::LANE_X1);
      @(posedge ref_clk);
      quadCmdMode <= q;
      dummySetting <= s;
      readByte <= b;
      @(posedge ref_clk);
      p0 = pulses;
      host.frame(ops[i], q, a, q ? 4 : lS[i], limit, dc, oe, dat);
      repeat (10) @(posedge ref_clk);
      #1;
      chk(8'(dc), 8'(ok ? d : 0), "dummy edges");
      chk(8'(pulses - p0), 8'(ok), "start pulses");
      if (ok)
      begin
         chk({4'h0, oe}, {4'h0, lm}, "lanes");
         chk(dat, b, "first byte");
         chk({3'h0, latencyUsed_ff}, 8'(d), "latency");
      end
   endtask

   initial
   begin
      nrst = 1'b0;
      dummySetting = 4'h0;
      quadCmdMode = 1'b0;
      readByte = 8'h00;
      rnd = 8'h56;
      repeat (16) @(posedge ref_clk);
      nrst <= 1'b1;
      for (int q = 0; q < 2; q++)
         for (int i = 0; i < 11; i++)
            run(i, q[0], 4'h0, 20);
      $display("test defaults done");
      run(0, 1'b0, 4'h1, 20);
      run(6, 1'b1, 4'hf, 20);
      run(3, 1'b0, 4'hf, 20);
      $display("test bounds done");
      run(0, 1'b0, 4'h0, 5);
      run(7, 1'b1, 4'h3, 20);
      $display("test abort done");
      repeat (24)
      begin
         x = rnd;
         rnd = nxt_rand(rnd);
         run(int'(x[6:0]) % 11, x[7], rnd[3:0], 20);
      end
      $display("test random done");
      tally_and_finish();
   end

   // 51 frames of at most about 50 reference cycles each; allow over fifteen times that
   initial
   begin
      repeat (40000) @(posedge ref_clk);
      errors++;
      $display("[ERR] %0t watchdog expired", $time);
      tally_and_finish();
   end
endmodule // read_dummy_latency_bench
